// File: core/xlsf_pkg.sv
// Package of constants and carrier types for the lane status flag bank
package xlsf_pkg;

    // ***************************************************
    // Register map
    // ***************************************************
    localparam logic [7:0]  XLSF_IDX_LANE_STATUS = 8'h16;
    localparam logic [7:0]  XLSF_IDX_SYNC_STATUS = 8'h17;
    localparam int          XLSF_ADDR_W          = 12;
    // Printed offsets are word indices, so the byte address is four times the index
    localparam logic [11:0] XLSF_ADDR_LANE_STATUS = {2'h0, XLSF_IDX_LANE_STATUS, 2'h0};
    localparam logic [11:0] XLSF_ADDR_SYNC_STATUS = {2'h0, XLSF_IDX_SYNC_STATUS, 2'h0};
    // Own register holding the per-lane pin select fields
    localparam logic [11:0] XLSF_ADDR_PIN_SELECT  = 12'h100;

    // ***************************************************
    // Field positions
    // ***************************************************
    localparam int XLSF_TXCOL_LSB  = 12;
    localparam int XLSF_DECERR_LSB = 8;
    localparam int XLSF_PASS_LSB   = 4;
    localparam int XLSF_LOST_LSB   = 0;
    localparam int XLSF_ALIGN_BIT  = 4;
    localparam int XLSF_RXCOL_LSB  = 0;
    localparam int XLSF_SEL_LSB    = 9;
    localparam int XLSF_SEL_STRIDE = 2;

    // ***************************************************
    // Reset values and encodings
    // ***************************************************
    localparam logic [3:0]  XLSF_PASS_RESET  = 4'hF;
    localparam logic [3:0]  XLSF_FLAG_RESET  = 4'h0;
    localparam logic [7:0]  XLSF_SEL_RESET   = 8'h00;
    localparam logic [31:0] XLSF_ZERO_WORD   = 32'h0000_0000;

    typedef enum logic [1:0] {
        XLSF_PIN_IDLE_LEVEL,
        XLSF_PIN_COMMA,
        XLSF_PIN_SIGNAL_LOST,
        XLSF_PIN_PATTERN_OK
    } xlsf_pin_sel_t;

    // ***************************************************
    // Carrier for per-lane events
    // ***************************************************
    typedef struct packed {
        logic [3:0] tx_collision;
        logic [3:0] decode_error;
        logic [3:0] pattern_error;
        logic [3:0] signal_lost;
        logic [3:0] rx_collision;
        logic [3:0] comma_seen;
        logic       lanes_aligned;
    } xlsf_events_t;

endpackage

// File: core/xlsf_lane_status_flags.sv
// Lane status flag bank with APB slave and multi-purpose pin outputs
//
// Overview of operation
// R1 - Each lane sets its transmit collision flag (bits 15:12, D to A) when its transmit FIFO self-resets.
// R2 - Every sticky flag of both status registers clears when software reads the register that holds it.
// R3 - Each lane sets its decode error flag (bits 11:8) on an invalid code word or disparity violation.
// R4 - Pattern-pass flags (bits 7:4) reset to 1 and drop to 0 when the pattern checker sees an error.
// R5 - Reading a pattern-pass flag that has dropped returns 0 and then restores it to 1.
// R6 - Each lane sets its signal-lost flag (bits 3:0) when that lane reports loss of signal.
// R7 - Collision, decode error and signal-lost flags of the lane status register reset to 0.
// R8 - Bits 15:5 of the sync status register always read zero.
// R9 - Bit 4 of the sync status register sets when all four lanes realign, and stays 0 until then.
// R10 - Each lane sets its receive collision flag (sync status bits 3:0) when its receive FIFO self-resets.
// R11 - Pin select 10 shows the lane's signal-lost flag, 11 its pattern-pass flag.
// R12 - An event in the same cycle as a clearing read stays set for the next read.
module xlsf_lane_status_flags
    import xlsf_pkg::*;
(
    input  wire logic                   mclk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   clk_en_in,
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [XLSF_ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]            pwdata_in,
    input  wire logic [3:0]             pstrb_in,
    input  wire xlsf_events_t           events_in,
    input  wire logic                   pin_idle_level_in,
    output logic [31:0]                 prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    output logic [3:0]                  multi_purpose_output_pin_out
);

    // ***************************************************
    // Reset release
    // ***************************************************
    logic rst_sync1_q;
    logic rst_sync2_q;
    logic rst_n;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end

    assign rst_n = rst_sync2_q;

    // ***************************************************
    // Event inputs come from other logic; two stages keep them safe
    // ***************************************************
    xlsf_events_t ev_meta_q;
    xlsf_events_t ev_q;
    logic         pin_idle_meta_q;
    logic         pin_idle_q;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ev_meta_q       <= '0;
            ev_q            <= '0;
            pin_idle_meta_q <= 1'b0;
            pin_idle_q      <= 1'b0;
        end else if (clk_en_in) begin
            ev_meta_q       <= events_in;
            ev_q            <= ev_meta_q;
            pin_idle_meta_q <= pin_idle_level_in;
            pin_idle_q      <= pin_idle_meta_q;
        end
    end

    // ***************************************************
    // APB decode
    // ***************************************************
    logic access;
    logic rd_lane;
    logic rd_sync;
    logic wr_sel;
    logic hit;

    assign access  = psel_in && penable_in && clk_en_in;
    assign rd_lane = access && !pwrite_in && (paddr_in == XLSF_ADDR_LANE_STATUS);
    assign rd_sync = access && !pwrite_in && (paddr_in == XLSF_ADDR_SYNC_STATUS);
    assign wr_sel  = access && pwrite_in && (paddr_in == XLSF_ADDR_PIN_SELECT);
    assign hit     = (paddr_in == XLSF_ADDR_LANE_STATUS) || (paddr_in == XLSF_ADDR_SYNC_STATUS)
                     || (paddr_in == XLSF_ADDR_PIN_SELECT);

    logic setup;
    logic wr_sel_ok;

    assign setup     = psel_in && !penable_in && clk_en_in;
    assign wr_sel_ok = wr_sel && pstrb_in[1] && pstrb_in[0];

    // Clear only what the read reported, so a flag set after the snapshot survives
    function automatic logic [3:0] sticky(input logic [3:0] cur, input logic [3:0] ev, input logic [3:0] clr);
        sticky = (cur & ~clr) | ev;
    endfunction

    // Restore only the zeros that were reported; a fresh error still wins
    function automatic logic [3:0] restore(input logic [3:0] cur, input logic [3:0] ev, input logic [3:0] low);
        restore = (cur | low) & ~ev;
    endfunction

    // ***************************************************
    // Flag registers and read words
    // ***************************************************
    logic [3:0]  tx_col_q;
    logic [3:0]  dec_err_q;
    logic [3:0]  pass_q;
    logic [3:0]  lost_q;
    logic [3:0]  rx_col_q;
    logic        align_q;
    logic [7:0]  pin_sel_q;
    logic [15:0] lane_word;
    logic [15:0] sync_word;
    logic [15:0] sel_word;
    logic [31:0] read_word;

    always_comb begin
        lane_word                       = 16'h0000;
        lane_word[XLSF_TXCOL_LSB +: 4]  = tx_col_q;                           // R1
        lane_word[XLSF_DECERR_LSB +: 4] = dec_err_q;                          // R3
        lane_word[XLSF_PASS_LSB +: 4]   = pass_q;                             // R4
        lane_word[XLSF_LOST_LSB +: 4]   = lost_q;                             // R6
    end

    always_comb begin
        sync_word                      = 16'h0000;                            // R8
        sync_word[XLSF_ALIGN_BIT]      = align_q;                             // R9
        sync_word[XLSF_RXCOL_LSB +: 4] = rx_col_q;                            // R10
    end

    assign sel_word = {pin_sel_q, 8'h00};

    always_comb begin
        unique case (paddr_in)
            XLSF_ADDR_LANE_STATUS: read_word = {16'h0000, lane_word};
            XLSF_ADDR_SYNC_STATUS: read_word = {16'h0000, sync_word};
            XLSF_ADDR_PIN_SELECT:  read_word = {16'h0000, sel_word};
            default:               read_word = XLSF_ZERO_WORD;
        endcase
    end

    // ***************************************************
    // Read snapshot and clear masks
    // ***************************************************
    logic [15:0] lane_snap_q;
    logic [15:0] sync_snap_q;
    logic [3:0]  tx_clr;
    logic [3:0]  dec_clr;
    logic [3:0]  lost_clr;
    logic [3:0]  pass_low;
    logic [3:0]  rx_clr;
    logic        align_clr;

    // The read returns this snapshot; the access edge clears its set sticky bits and restores its zero pass bits
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            lane_snap_q <= 16'h0000;
            sync_snap_q <= 16'h0000;
        end else if (setup && !pwrite_in) begin
            lane_snap_q <= (paddr_in == XLSF_ADDR_LANE_STATUS) ? lane_word : 16'h0000;  // R12
            sync_snap_q <= (paddr_in == XLSF_ADDR_SYNC_STATUS) ? sync_word : 16'h0000;  // R12
        end
    end

    assign tx_clr    = rd_lane ? lane_snap_q[XLSF_TXCOL_LSB +: 4] : 4'h0;              // R2
    assign dec_clr   = rd_lane ? lane_snap_q[XLSF_DECERR_LSB +: 4] : 4'h0;             // R2
    assign lost_clr  = rd_lane ? lane_snap_q[XLSF_LOST_LSB +: 4] : 4'h0;               // R2
    assign pass_low  = rd_lane ? ~lane_snap_q[XLSF_PASS_LSB +: 4] : 4'h0;              // R5
    assign rx_clr    = rd_sync ? sync_snap_q[XLSF_RXCOL_LSB +: 4] : 4'h0;              // R2
    assign align_clr = rd_sync && sync_snap_q[XLSF_ALIGN_BIT];                         // R2

    // ***************************************************
    // Lane status flags, one block per field
    // ***************************************************
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_col_q <= XLSF_FLAG_RESET;                                      // R7
        end else if (clk_en_in) begin
            tx_col_q <= sticky(tx_col_q, ev_q.tx_collision, tx_clr);          // R1 R2 R12
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            dec_err_q <= XLSF_FLAG_RESET;                                     // R7
        end else if (clk_en_in) begin
            dec_err_q <= sticky(dec_err_q, ev_q.decode_error, dec_clr);       // R3 R2 R12
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            lost_q <= XLSF_FLAG_RESET;                                        // R7
        end else if (clk_en_in) begin
            lost_q <= sticky(lost_q, ev_q.signal_lost, lost_clr);             // R6 R2 R12
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pass_q <= XLSF_PASS_RESET;                                        // R4
        end else if (clk_en_in) begin
            pass_q <= restore(pass_q, ev_q.pattern_error, pass_low);          // R4 R5 R12
        end
    end

    // ***************************************************
    // Sync status flags
    // ***************************************************
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_col_q <= XLSF_FLAG_RESET;
        end else if (clk_en_in) begin
            rx_col_q <= sticky(rx_col_q, ev_q.rx_collision, rx_clr);          // R10 R2 R12
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            align_q <= 1'b0;
        end else if (clk_en_in) begin
            align_q <= (align_q && !align_clr) || ev_q.lanes_aligned;         // R9 R2 R12
        end
    end

    // ***************************************************
    // Pin select register, two bits per lane
    // ***************************************************
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_sel_q <= XLSF_SEL_RESET;
        end else if (wr_sel_ok) begin
            pin_sel_q <= pwdata_in[XLSF_SEL_LSB-1 +: 8];
        end
    end

    // ***************************************************
    // Read answer
    // ***************************************************
    // Zero-wait slave: pready answers in the first access cycle
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pready_out <= 1'b0;
        end else if (clk_en_in) begin
            pready_out <= setup;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_out <= 1'b0;
        end else if (clk_en_in) begin
            pslverr_out <= setup && !hit;
        end
    end

    // Read data holds until the next read setup
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            prdata_out <= XLSF_ZERO_WORD;
        end else if (setup && !pwrite_in) begin
            prdata_out <= read_word;
        end
    end

    // ***************************************************
    // Multi-purpose pins
    // ***************************************************
    function automatic logic pin_level(input logic [1:0] sel, input logic comma, input logic lost,
                                       input logic pass, input logic idle);
        unique case (xlsf_pin_sel_t'(sel))
            XLSF_PIN_IDLE_LEVEL:  pin_level = idle;
            XLSF_PIN_COMMA:       pin_level = comma;
            XLSF_PIN_SIGNAL_LOST: pin_level = lost;                           // R11
            XLSF_PIN_PATTERN_OK:  pin_level = pass;                           // R11
        endcase
    endfunction

    logic [3:0] pin_next;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_next[i] = pin_level(pin_sel_q[i*XLSF_SEL_STRIDE +: 2], ev_q.comma_seen[i], lost_q[i],
                                    pass_q[i], pin_idle_q);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            multi_purpose_output_pin_out <= 4'h0;
        end else if (clk_en_in) begin
            multi_purpose_output_pin_out <= pin_next;
        end
    end

endmodule

// File: test/xlsf_checker.sv
// Assertions on the APB answer and flag clearing of the lane status flag bank
module xlsf_checker
    import xlsf_pkg::*;
(
    input wire logic                   mclk_in,
    input wire logic                   rst_n_in,
    input wire logic                   clk_en_in,
    input wire logic                   psel_in,
    input wire logic                   penable_in,
    input wire logic                   pwrite_in,
    input wire logic [XLSF_ADDR_W-1:0] paddr_in,
    input wire xlsf_events_t           events_in,
    input wire logic [31:0]            prdata_out,
    input wire logic                   pready_out,
    input wire logic                   pslverr_out
);
    // ***************
    // Properties
    // ***************
    default clocking @(posedge mclk_in); endclocking
    // Frozen clock enable stalls all but the reset synchronizer, so attempts are dropped then
    default disable iff (!rst_n_in || !clk_en_in);
    logic mapped;
    assign mapped = paddr_in inside {XLSF_ADDR_LANE_STATUS, XLSF_ADDR_SYNC_STATUS, XLSF_ADDR_PIN_SELECT};
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence lane_rd_s;
        pready_out && psel_in && !pwrite_in && paddr_in == XLSF_ADDR_LANE_STATUS;
    endsequence
    chk_ready_answer: assert property (setup_s |=> pready_out) else $error("no answer after setup");
    chk_ready_pulse: assert property (pready_out |=> !pready_out) else $error("answer too long");
    chk_ready_cause: assert property ($rose(pready_out) |-> $past(psel_in) && !$past(penable_in))
        else $error("answer without setup");
    chk_upper_zero: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_sync_reserved: assert property (pready_out && !pwrite_in && paddr_in == XLSF_ADDR_SYNC_STATUS
        |-> prdata_out[15:5] == 11'h000) else $error("reserved sync bits set");
    chk_unmapped_err: assert property (pready_out && !pwrite_in && !mapped
        |-> pslverr_out && prdata_out == XLSF_ZERO_WORD) else $error("unmapped read accepted");
    chk_mapped_ok: assert property (pready_out && mapped |-> !pslverr_out) else $error("mapped error");
    chk_read_clears: assert property (lane_rd_s ##3 (lane_rd_s ##0 ($past(events_in, 4) == '0
        && $past(events_in, 5) == '0 && $past(events_in, 6) == '0)) |-> prdata_out[15:0] == 16'h00F0)
        else $error("flags not cleared");
endmodule
bind xlsf_lane_status_flags xlsf_checker chk_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .events_in(events_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));

// File: test/xlsf_lane_status_flags_tb.sv
// Self-checking bench for the lane status flag bank
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module xlsf_lane_status_flags_tb import xlsf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic         mclk_in, rst_n_in, clk_en_in, psel_in, penable_in, pwrite_in, pin_idle_level_in;
    logic         pready_out, pslverr_out, err;
    logic [11:0]  paddr_in;
    logic [31:0]  pwdata_in, prdata_out, rd;
    logic [3:0]   pstrb_in, multi_purpose_output_pin_out;
    xlsf_events_t events_in;
    int           mismatches, total_checks;
    xlsf_lane_status_flags dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .events_in(events_in), .pin_idle_level_in(pin_idle_level_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .multi_purpose_output_pin_out(multi_purpose_output_pin_out));
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    // ***************
    // Bus and helpers
    // ***************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, 1'b0, wr, a, d};
        @(posedge mclk_in);
        penable_in <= 1'b1;
        n = 0;
        // Pready is sampled at the rising edge; answer and release share that edge
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        {rd, err} = {prdata_out, pslverr_out};
        {psel_in, penable_in} <= 2'h0;
        if (n >= 20) mismatches++;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic e);
        apb(1'b0, a, 32'h0);
        `CHK("read data", x, rd)
        `CHK("error flag", e, err)
    endtask
    task automatic pulse(input xlsf_events_t e);
        @(posedge mclk_in);
        events_in <= e;
        @(posedge mclk_in);
        events_in <= '0;
    endtask
    // ***************
    // Scenarios
    // ***************
    task automatic t_flags;
        xlsf_events_t e;
        logic [31:0] x;
        for (int i = 0; i < 4; i++) begin
            e = '0;
            e.tx_collision[i] = 1'b1;
            e.decode_error[(i+1)%4] = 1'b1;
            e.signal_lost[(i+2)%4] = 1'b1;
            e.pattern_error[(i+3)%4] = 1'b1;
            e.rx_collision[i] = 1'b1;
            e.lanes_aligned = 1'b1;
            pulse(e);
            repeat (5) @(posedge mclk_in);
            x = (32'h1 << (12+i)) | (32'h1 << (8+(i+1)%4)) | (32'h1 << ((i+2)%4));
            x = x | (32'h00F0 & ~(32'h1 << (4+(i+3)%4)));
            rdchk(XLSF_ADDR_LANE_STATUS, x, 1'b0);
            rdchk(XLSF_ADDR_LANE_STATUS, 32'h00F0, 1'b0);
            rdchk(XLSF_ADDR_SYNC_STATUS, (32'h1 << i) | 32'h10, 1'b0);
            rdchk(XLSF_ADDR_SYNC_STATUS, 32'h0, 1'b0);
        end
    endtask
    task automatic t_pins;
        xlsf_events_t e;
        apb(1'b1, XLSF_ADDR_PIN_SELECT, 32'h0000_4E00);
        rdchk(XLSF_ADDR_PIN_SELECT, 32'h0000_4E00, 1'b0);
        repeat (4) @(posedge mclk_in);
        `CHK("pins", 4'h6, multi_purpose_output_pin_out)
        e = '0;
        e.comma_seen = 4'h8;
        e.signal_lost = 4'h1;
        e.pattern_error = 4'h2;
        @(posedge mclk_in);
        events_in <= e;
        e.signal_lost = 4'h0;
        e.pattern_error = 4'h0;
        @(posedge mclk_in);
        events_in <= e;
        repeat (5) @(posedge mclk_in);
        `CHK("pins", 4'hD, multi_purpose_output_pin_out)
        events_in <= '0;
        rdchk(XLSF_ADDR_LANE_STATUS, 32'h00D1, 1'b0);
        repeat (5) @(posedge mclk_in);
        `CHK("pins", 4'h6, multi_purpose_output_pin_out)
        pin_idle_level_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        `CHK("pins", 4'h2, multi_purpose_output_pin_out)
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {clk_en_in, pin_idle_level_in, pstrb_in, events_in} = {1'b1, 1'b1, 4'hF, 25'h0};
        {mismatches, total_checks} = {32'h0, 32'h0};
        repeat (12) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rdchk(XLSF_ADDR_LANE_STATUS, 32'h00F0, 1'b0);
        rdchk(XLSF_ADDR_SYNC_STATUS, 32'h0, 1'b0);
        t_flags();
        // Lane A signal-lost lands on the flag after the first read took its snapshot
        pulse(25'h0_0200);
        rdchk(XLSF_ADDR_LANE_STATUS, 32'h00F0, 1'b0);
        rdchk(XLSF_ADDR_LANE_STATUS, 32'h00F1, 1'b0);
        apb(1'b1, XLSF_ADDR_LANE_STATUS, 32'h0000_FFFF);
        rdchk(XLSF_ADDR_LANE_STATUS, 32'h00F0, 1'b0);
        rdchk(12'h060, 32'h0, 1'b1);
        t_pins();
        end_sim();
    end
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
endmodule
